// >>> dv/ctcbi_checker.sv
// Checker of the link between the CPU end and the counter/timer end.
// Assumes it watches the interface signals directly, in one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ctcbi_checker (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// CPU strobes
	input wire logic chip_enable_n,
	input wire logic io_request_n,
	input wire logic read_n,
	input wire logic opcode_fetch_n,
	// Device side
	input wire logic [7:0] dev_data,
	input wire logic dev_data_oe,
	input wire logic interrupt_n,
	input wire logic chain_enable_in,
	input wire logic chain_enable_out
);
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_B);
	// First edge of a read cycle
	sequence s_rd_start;
		!io_request_n && $past(io_request_n) && !read_n && !chip_enable_n && opcode_fetch_n;
	endsequence
	// First edge of an acknowledge
	sequence s_ack_start;
		!io_request_n && $past(io_request_n) && !opcode_fetch_n;
	endsequence
	// Request held through the two settling waits
	sequence s_ack_held;
		(!io_request_n && !opcode_fetch_n)[*3];
	endsequence
	property p_read_drive;
		s_rd_start |=> dev_data_oe;
	endproperty
	property p_write_quiet;
		(!io_request_n && read_n && opcode_fetch_n) |-> !dev_data_oe;
	endproperty
	property p_oe_needs_io;
		dev_data_oe |-> !io_request_n;
	endproperty
	property p_ack_lead;
		s_ack_start |-> !$past(opcode_fetch_n) && !$past(opcode_fetch_n, 2) && read_n;
	endproperty
	property p_ack_waits;
		s_ack_start |-> s_ack_held;
	endproperty
	property p_ack_vec;
		s_ack_start ##0 (chain_enable_in && !interrupt_n) |=> dev_data_oe && !dev_data[0];
	endproperty
	property p_chain_shut;
		(!chain_enable_in && !opcode_fetch_n) |-> !dev_data_oe;
	endproperty
	property p_chain_off;
		!chain_enable_in |-> !chain_enable_out;
	endproperty
	property p_chain_ack;
		(!opcode_fetch_n && !interrupt_n) |-> !chain_enable_out;
	endproperty
	// Request state frozen while fetch leads the acknowledge
	property p_freeze;
		(!opcode_fetch_n && io_request_n && !$past(opcode_fetch_n)) |-> $stable(interrupt_n);
	endproperty
	a_read_drive: assert property (p_read_drive) else $error("read data not driven in T3");
	a_write_quiet: assert property (p_write_quiet) else $error("device drives on write");
	a_oe_needs_io: assert property (p_oe_needs_io) else $error("device drives idle bus");
	a_ack_lead: assert property (p_ack_lead) else $error("fetch lead wrong");
	a_ack_waits: assert property (p_ack_waits) else $error("acknowledge too short");
	a_ack_vec: assert property (p_ack_vec) else $error("vector not driven");
	a_chain_shut: assert property (p_chain_shut) else $error("vector with chain closed");
	a_chain_off: assert property (p_chain_off) else $error("chain out open");
	a_chain_ack: assert property (p_chain_ack) else $error("chain out open on ack");
	a_freeze: assert property (p_freeze) else $error("request changed in fetch");
endmodule : ctcbi_checker
`default_nettype wire

// >>> dv/tb.sv
// Testbench: CPU end and device end joined by the link, driven from the user side.
// Assumes the rtl files are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rst_b, req_valid, req_ready, req_write, req_ack, rsp_valid, irq_pending;
	logic [1:0] req_channel;
	logic [7:0] req_data, rsp_data, vec;
	logic [3:0] req_extra_waits, ext_trig, zc;
	logic [31:0] seed;
	logic [7:0] tc [4];
	logic [7:0] rsp_q [$];
	logic [3:0] zc_q [$];
	int error_cnt, checks;
	ctcbi_if i_ctcbi_if ();
	ctcbi_dev i_ctcbi_dev (.CLK_SYS(clk), .RST_B(rst_b), .BUS(i_ctcbi_if.device),
		.EXT_CLOCK_TRIGGER(ext_trig), .ZERO_COUNT_OUT(zc));
	ctcbi_host i_ctcbi_host (.CLK_SYS(clk), .RST_B(rst_b), .BUS(i_ctcbi_if.host),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
		.REQ_ACK(req_ack), .REQ_CHANNEL(req_channel), .REQ_DATA(req_data),
		.REQ_EXTRA_WAITS(req_extra_waits), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
		.IRQ_PENDING(irq_pending));
	ctcbi_checker i_ctcbi_checker (.CLK_SYS(clk), .RST_B(rst_b),
		.chip_enable_n(i_ctcbi_if.chip_enable_n), .io_request_n(i_ctcbi_if.io_request_n),
		.read_n(i_ctcbi_if.read_n), .opcode_fetch_n(i_ctcbi_if.opcode_fetch_n),
		.dev_data(i_ctcbi_if.dev_data), .dev_data_oe(i_ctcbi_if.dev_data_oe),
		.interrupt_n(i_ctcbi_if.interrupt_n), .chain_enable_in(i_ctcbi_if.chain_enable_in),
		.chain_enable_out(i_ctcbi_if.chain_enable_out));
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmp_zc(input logic [3:0] exp, input logic [3:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: zero pulse %h, expected %h", $time, got, exp);
		end
	endtask : cmp_zc
	task automatic cmp_flag(input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : cmp_flag
	task automatic wrap_up();
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	// Wait until the host is idle and every note is used; bounded so a hang shows
	task automatic settle(input int lim);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((req_ready !== 1'b1 || rsp_q.size() > 0 || zc_q.size() > 0) && n < lim);
		if (n >= lim) begin
			error_cnt++;
			$display("unexpected at %0t: no answer", $time);
		end
	endtask : settle
	// One user request, held for one taking edge, random extra waits
	task automatic host_op(input logic wr, input logic ack, input logic [1:0] ch,
		input logic [7:0] d);
		@(posedge clk);
		seed = xs(seed);
		req_valid <= 1'b1;
		req_write <= wr;
		req_ack <= ack;
		req_channel <= ch;
		req_data <= d;
		req_extra_waits <= {2'b00, seed[1:0]};
		@(posedge clk);
		req_valid <= 1'b0;
		settle(100);
	endtask : host_op
	// trigger period kept at several clocks
	task automatic trig(input int ch);
		seed = xs(seed);
		@(posedge clk);
		ext_trig <= ext_trig | (4'h1 << ch);
		repeat (3) @(posedge clk);
		ext_trig <= ext_trig & ~(4'h1 << ch);
		repeat (3 + seed[1:0]) @(posedge clk);
	endtask : trig
	// Oldest note against each answer and each zero pulse
	always @(posedge clk) begin
		if (rsp_valid === 1'b1) begin
			if (rsp_q.size() > 0) begin
				cmp(rsp_q.pop_front(), rsp_data);
			end else begin
				error_cnt++;
				$display("unexpected at %0t: answer %h with none noted", $time, rsp_data);
			end
		end
		if (rst_b === 1'b1 && zc !== 4'h0) begin
			cmp_zc((zc_q.size() > 0) ? zc_q.pop_front() : 4'h0, zc);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
	initial begin
		seed = 32'h6719F40F;
		error_cnt = 0;
		checks = 0;
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_ack = 1'b0;
		req_channel = 2'h0;
		req_data = 8'h00;
		req_extra_waits = 4'h0;
		ext_trig = 4'h0;
		i_ctcbi_if.chain_enable_in = 1'b1;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		settle(100);
		seed = xs(seed);
		vec = {seed[7:3], 3'b000};
		host_op(1'b1, 1'b0, 2'd0, vec);
		// Counter mode with interrupts on channels 1 and 2
		for (int ch = 1; ch < 3; ch++) begin
			seed = xs(seed);
			tc[ch] = 8'h02 + {6'h00, seed[1:0]};
			host_op(1'b1, 1'b0, ch[1:0], 8'hD5);
			host_op(1'b1, 1'b0, ch[1:0], tc[ch]);
			rsp_q.push_back(tc[ch]);
			host_op(1'b0, 1'b0, ch[1:0], 8'h00);
			for (int k = 1; k < tc[ch]; k++)
				trig(ch);
			rsp_q.push_back(8'h01);
			host_op(1'b0, 1'b0, ch[1:0], 8'h00);
			zc_q.push_back(4'h1 << ch);
			trig(ch);
			settle(100);
			cmp_flag(1'b1, irq_pending);
		end
		// Closed chain leaves the bus idle
		@(posedge clk);
		i_ctcbi_if.chain_enable_in <= 1'b0;
		rsp_q.push_back(8'hFF);
		host_op(1'b0, 1'b1, 2'd0, 8'h00);
		@(posedge clk);
		i_ctcbi_if.chain_enable_in <= 1'b1;
		rsp_q.push_back({vec[7:3], 3'b010});
		host_op(1'b0, 1'b1, 2'd0, 8'h00);
		cmp_flag(1'b0, i_ctcbi_if.chain_enable_out);
		// Channel 2 must wait while channel 1 is in service
		rsp_q.push_back(8'hFF);
		host_op(1'b0, 1'b1, 2'd0, 8'h00);
		// Return opcodes fetched: channel 1 leaves service, channel 2 gets through
		host_op(1'b1, 1'b1, 2'd0, ctcbi_pkg::RETURN_FROM_INTERRUPT_OPCODE_FIRST);
		host_op(1'b1, 1'b1, 2'd0, ctcbi_pkg::RETURN_FROM_INTERRUPT_OPCODE_SECOND);
		cmp_flag(1'b1, i_ctcbi_if.chain_enable_out);
		rsp_q.push_back({vec[7:3], 3'b100});
		host_op(1'b0, 1'b1, 2'd0, 8'h00);
		// Timer on channel 3, prescaler 16, stopped after its first pulse
		host_op(1'b1, 1'b0, 2'd3, 8'h05);
		zc_q.push_back(4'h8);
		host_op(1'b1, 1'b0, 2'd3, 8'h02);
		host_op(1'b1, 1'b0, 2'd3, 8'h03);
		// Triggered timer: silent until its edge, then one pulse
		host_op(1'b1, 1'b0, 2'd3, 8'h1D);
		host_op(1'b1, 1'b0, 2'd3, 8'h02);
		repeat (40) @(posedge clk);
		zc_q.push_back(4'h8);
		trig(3);
		settle(100);
		host_op(1'b1, 1'b0, 2'd3, 8'h03);
		wrap_up();
	end
endmodule : tb
`default_nettype wire

// >>> rtl/ctcbi_chan.sv
// One counter/timer channel: down-counter, prescaler, trigger sync and zero pulse.
// Assumes writes arrive as one-cycle strobes on CLK_SYS from the device end.
`timescale 1ns/1ps
`default_nettype none
module ctcbi_chan #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register writes
	input wire logic wr_ctrl,
	input wire logic wr_tc,
	input wire logic [W-1:0] wr_data,
	// Trigger pin, asynchronous
	input wire logic trig_pin,
	// Status
	output logic [W-1:0] count,
	output logic zc_pulse,
	output logic int_en,
	output logic tc_pending
);
	logic [7:0] ctrl_q, ctrl_d;
	logic [W-1:0] tc_q, tc_d, cnt_q, cnt_d;
	logic [8:0] pre_q, pre_d;
	logic run_q, run_d, tcp_q, tcp_d, arm_q, arm_d;
	logic s1_q, s2_q, s3_q, zc_q, zc_d;
	logic edge_seen;

	// Two-stage sync, third stage only for edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= trig_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Edge of chosen polarity; a late edge simply lands a cycle later in the sync
	assign edge_seen = ctrl_q[ctcbi_pkg::CW_EDGE_POS] ? (s2_q & ~s3_q) : (~s2_q & s3_q);

	// Next-state of channel control and counting
	always_comb begin
		ctrl_d = ctrl_q;
		tc_d = tc_q;
		cnt_d = cnt_q;
		pre_d = pre_q;
		run_d = run_q;
		tcp_d = tcp_q;
		arm_d = arm_q;
		zc_d = 1'b0;
		if (wr_tc) begin
			tc_d = wr_data;
			tcp_d = 1'b0;
			if (!run_q || ctrl_q[ctcbi_pkg::CW_RESET]) begin
				cnt_d = wr_data;
				pre_d = ctrl_q[ctcbi_pkg::CW_PRESC256] ? ctcbi_pkg::PRESC_LONG
					: ctcbi_pkg::PRESC_SHORT;
				ctrl_d[ctcbi_pkg::CW_RESET] = 1'b0;
				run_d = ctrl_q[ctcbi_pkg::CW_COUNTER] | ~ctrl_q[ctcbi_pkg::CW_TRIG_EN];
				arm_d = ~run_d;
			end
		end else if (wr_ctrl) begin
			ctrl_d = wr_data;
			tcp_d = wr_data[ctcbi_pkg::CW_TC_NEXT];
			if (wr_data[ctcbi_pkg::CW_RESET]) begin
				run_d = 1'b0;
				arm_d = 1'b0;
			end
		end else if (arm_q && edge_seen) begin
			// [RULE_10] Trigger starts timing
			// [RULE_11] Late edge one cycle later
			run_d = 1'b1;
			arm_d = 1'b0;
		end else if (run_q) begin
			if (ctrl_q[ctcbi_pkg::CW_COUNTER]) begin
				// [RULE_06] Counter edge decrements
				// [RULE_07] Late edge postponed, not lost
				if (edge_seen) begin
					cnt_d = cnt_q - 1'b1;
				end
			end else if (pre_q == 9'h001) begin
				pre_d = ctrl_q[ctcbi_pkg::CW_PRESC256] ? ctcbi_pkg::PRESC_LONG
					: ctcbi_pkg::PRESC_SHORT;
				cnt_d = cnt_q - 1'b1;
			end else begin
				pre_d = pre_q - 9'h001;
			end
			// [RULE_09] Zero pulse on 1 to 0
			if (cnt_q == {{(W-1){1'b0}}, 1'b1} && cnt_d != cnt_q) begin
				zc_d = 1'b1;
				cnt_d = tc_q;
			end
		end
	end

	// Registering of channel state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q <= ctcbi_pkg::CTRL_RST;
			tc_q <= ctcbi_pkg::TC_RST;
			cnt_q <= '0;
			pre_q <= ctcbi_pkg::PRESC_SHORT;
			run_q <= 1'b0;
			tcp_q <= 1'b0;
			arm_q <= 1'b0;
			zc_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			tc_q <= tc_d;
			cnt_q <= cnt_d;
			pre_q <= pre_d;
			run_q <= run_d;
			tcp_q <= tcp_d;
			arm_q <= arm_d;
			zc_q <= zc_d;
		end
	end

	assign count = cnt_q;
	assign zc_pulse = zc_q;
	assign int_en = ctrl_q[ctcbi_pkg::CW_INT_EN];
	assign tc_pending = tcp_q;
endmodule : ctcbi_chan
`default_nettype wire

// >>> rtl/ctcbi_dev.sv
// Device end: four counter/timer channels, CPU I/O decode and interrupt daisy chain.
// Assumes all bus strobes come from a CPU on CLK_SYS; trigger pins are asynchronous.
//
// Contract
// [RULE_01] Selected cycle with read high is write
// [RULE_02] Write starts in T2, 2-bit select
// [RULE_03] Write data captured at T3 edge
// [RULE_04] Opcode fetch with request means acknowledge
// [RULE_05] Read drives count by T3, no waits
// [RULE_06] Counter mode: external edge decrements
// [RULE_07] Late counter edge delayed one cycle
// [RULE_08] Trigger period at least two clocks
// [RULE_09] Zero pulse when count steps 1 to 0
// [RULE_10] Timer starts on second following edge
// [RULE_11] Late trigger delays start one cycle
// [RULE_12] Enabled channel requests at every zero
// [RULE_13] Device gives low vector byte
// [RULE_14] Lower priority cannot preempt higher service
// [RULE_15] Channel 0 highest priority
// [RULE_16] Requests frozen during opcode fetch
// [RULE_17] CPU leads fetch by two, read high
// [RULE_18] Chain enabled: winner drives vector
// [RULE_19] Two auto waits, more tolerated
// [RULE_20] First return byte reopens chain input
// [RULE_21] Second return byte ends service
// [RULE_22] Channel 0 bit0 clear loads vector
// [RULE_23] Channel number in vector bits 1-2
// [RULE_24] Chain output low on service or request
`timescale 1ns/1ps
`default_nettype none
module ctcbi_dev #(
	parameter int NCH = ctcbi_pkg::NUM_CH
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// CPU link
	ctcbi_if.device BUS,
	// Channel pins
	input wire logic [NCH-1:0] EXT_CLOCK_TRIGGER,
	output logic [NCH-1:0] ZERO_COUNT_OUT
);
	// Decode of the CPU strobes
	logic [1:0] sel;
	logic sel_cyc, io_wr, io_rd, ack_cyc, io_q, io_d;
	logic [NCH-1:0] wr_ctrl, wr_tc, zc, ien, tcp;
	logic [7:0] cnt [NCH];
	logic [NCH-1:0] req_q, req_d, srv_q, srv_d;
	logic [NCH-1:0] pend_q, pend_d;
	logic [4:0] vec_q, vec_d;
	logic [7:0] dout_q, dout_d;
	logic oe_q, oe_d, ed_q, ed_d, fetch_q, fetch_d;
	logic [1:0] win;
	logic any_req, any_srv, hi_srv, hi_req, ack_take;

	assign sel = {BUS.channel_select_hi, BUS.channel_select_lo};
	assign sel_cyc = ~BUS.chip_enable_n & ~BUS.io_request_n;
	// [RULE_04] Acknowledge vs register access
	assign ack_cyc = ~BUS.io_request_n & ~BUS.opcode_fetch_n;
	// [RULE_01] Internal write enable
	// io_q masks T3, so each write lands exactly once
	// [RULE_02] Cycle begins at request
	assign io_wr = sel_cyc & BUS.read_n & BUS.opcode_fetch_n & ~io_q;
	assign io_rd = sel_cyc & ~BUS.read_n & BUS.opcode_fetch_n;

	// Write steering per channel; vector shares channel 0's port
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			// [RULE_03] Capture on T3 edge
			assign wr_tc[i] = io_wr && sel == 2'(i) && tcp[i];
			assign wr_ctrl[i] = io_wr && sel == 2'(i) && !tcp[i]
				&& BUS.data_bus[ctcbi_pkg::CW_IS_CTRL];
			ctcbi_chan #(.W(8)) u_chan (
				.clk(CLK_SYS),
				.rst_b(RST_B),
				.wr_ctrl(wr_ctrl[i]),
				.wr_tc(wr_tc[i]),
				.wr_data(BUS.data_bus),
				.trig_pin(EXT_CLOCK_TRIGGER[i]),
				.count(cnt[i]),
				.zc_pulse(zc[i]),
				.int_en(ien[i]),
				.tc_pending(tcp[i])
			);
		end
	endgenerate
	assign ZERO_COUNT_OUT = zc;

	// Scanning downwards lets the lowest requesting number win
	// [RULE_15] Fixed priority, channel 0 first
	always_comb begin
		win = 2'h0;
		for (int k = NCH - 1; k >= 0; k--) begin
			if (req_q[k]) begin
				win = k[1:0];
			end
		end
	end
	// Summary flags for the chain and the request line
	assign any_req = |req_q;
	assign any_srv = |srv_q;
	// A channel in service blocks itself and every lower one; a higher
	// channel still gets through and preempts it
	// [RULE_14] No preemption by lower priority
	always_comb begin
		hi_srv = 1'b0;
		for (int k = 0; k < NCH; k++) begin
			if (srv_q[k] && k[1:0] <= win) begin
				hi_srv = 1'b1;
			end
		end
	end
	assign hi_req = any_req & ~hi_srv;
	// [RULE_18] Winner answers when chain enabled
	assign ack_take = ack_cyc & ~io_q & BUS.chain_enable_in & hi_req;

	// Next state for requests, service, vector, data and opcode snooping
	always_comb begin
		io_d = ~BUS.io_request_n;
		req_d = req_q;
		srv_d = srv_q;
		vec_d = vec_q;
		dout_d = dout_q;
		oe_d = 1'b0;
		ed_d = ed_q;
		fetch_d = ~BUS.opcode_fetch_n & BUS.io_request_n & ~BUS.read_n;
		// [RULE_12] Request on each zero, kept pending through a fetch
		pend_d = pend_q | (zc & ien);
		// Holding back only the update keeps the chain steady without losing a zero
		// [RULE_16] Freeze requests during fetch
		if (BUS.opcode_fetch_n) begin
			req_d = req_q | pend_d;
			pend_d = '0;
		end
		// [RULE_22] Vector load on channel 0
		if (io_wr && sel == 2'h0 && !tcp[0] && !BUS.data_bus[ctcbi_pkg::CW_IS_CTRL]) begin
			vec_d = BUS.data_bus[7:ctcbi_pkg::VEC_HI_LSB];
		end
		// [RULE_05] Sample count, drive by T3
		if (io_rd) begin
			dout_d = cnt[sel];
			oe_d = 1'b1;
		end
		// [RULE_13] Low pointer byte from device
		// [RULE_23] Channel code in bits 1-2
		// [RULE_19] Held while waits last
		if (ack_take) begin
			dout_d = {vec_q, win, 1'b0};
			req_d[win] = 1'b0;
			srv_d[win] = 1'b1;
			oe_d = 1'b1;
		end else if (ack_cyc && oe_q) begin
			oe_d = 1'b1;
		end
		// Any other fetched byte cancels a half-seen return sequence
		// Read going high after the fetch strobe (start of T3) marks the opcode latch point
		if (fetch_q && BUS.read_n) begin
			ed_d = 1'b0;
			// [RULE_20] First return byte seen
			if (BUS.data_bus == ctcbi_pkg::RETURN_FROM_INTERRUPT_OPCODE_FIRST) begin
				ed_d = 1'b1;
			end else if (ed_q && BUS.data_bus == ctcbi_pkg::RETURN_FROM_INTERRUPT_OPCODE_SECOND
				&& BUS.chain_enable_in) begin
				// [RULE_21] Clear lowest-numbered service
				for (int k = NCH - 1; k >= 0; k--) begin
					if (srv_q[k]) begin
						srv_d = srv_q & ~(NCH'(1) << k);
					end
				end
			end
		end
	end

	// Registering of interrupt and bus state
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			io_q <= 1'b0;
			req_q <= '0;
			pend_q <= '0;
			srv_q <= '0;
			vec_q <= ctcbi_pkg::VEC_HI_RST;
			dout_q <= 8'h00;
			oe_q <= 1'b0;
			ed_q <= 1'b0;
			fetch_q <= 1'b0;
		end else begin
			io_q <= io_d;
			req_q <= req_d;
			pend_q <= pend_d;
			srv_q <= srv_d;
			vec_q <= vec_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
			ed_q <= ed_d;
			fetch_q <= fetch_d;
		end
	end

	// Bus outputs: the device drives only while the request is low, so it never
	// meets the CPU's own drive of a write or fetch byte
	assign BUS.dev_data = dout_q;
	assign BUS.dev_data_oe = oe_q & ~BUS.io_request_n;
	assign BUS.interrupt_n = ~hi_req;
	// Chain output is combinational so a pending request shuts lower devices as soon as the opcode fetch starts
	// [RULE_24] Chain output gating
	// [RULE_20] After first return byte only service blocks
	assign BUS.chain_enable_out = BUS.chain_enable_in & ~any_srv
		& ~(~BUS.opcode_fetch_n & any_req & ~ed_q);
endmodule : ctcbi_dev
`default_nettype wire

// >>> rtl/ctcbi_host.sv
// CPU end: runs I/O writes, reads and interrupt acknowledges on the link.
// Assumes a user issues one request at a time and waits for done.
`timescale 1ns/1ps
`default_nettype none
module ctcbi_host (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_B,
	// CPU link
	ctcbi_if.host BUS,
	// User request
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_WRITE,
	input wire logic REQ_ACK,
	input wire logic [1:0] REQ_CHANNEL,
	input wire logic [7:0] REQ_DATA,
	input wire logic [3:0] REQ_EXTRA_WAITS,
	// Answer
	output logic RSP_VALID,
	output logic [7:0] RSP_DATA,
	output logic IRQ_PENDING
);
	ctcbi_pkg::ctcbi_cpu_st_t st_q, st_d;
	logic wr_q, wr_d, ack_q, ack_d;
	logic [1:0] ch_q, ch_d;
	logic [7:0] dat_q, dat_d, rsp_q, rsp_d;
	logic [3:0] cnt_q, cnt_d;
	logic rv_q, rv_d;
	logic fet, t1t2, t2t3;

	// Bus cycle sequencer
	always_comb begin
		st_d = st_q;
		wr_d = wr_q;
		ack_d = ack_q;
		ch_d = ch_q;
		dat_d = dat_q;
		cnt_d = cnt_q;
		rsp_d = rsp_q;
		rv_d = 1'b0;
		unique case (st_q)
			ctcbi_pkg::CPU_IDLE: begin
				if (REQ_VALID) begin
					wr_d = REQ_WRITE;
					ack_d = REQ_ACK;
					ch_d = REQ_CHANNEL;
					dat_d = REQ_DATA;
					cnt_d = 4'(ctcbi_pkg::ACK_M1_LEAD - 1);
					st_d = (REQ_ACK && !REQ_WRITE) ? ctcbi_pkg::CPU_ACKM : ctcbi_pkg::CPU_T1;
				end
			end
			ctcbi_pkg::CPU_T1: st_d = ctcbi_pkg::CPU_T2;
			ctcbi_pkg::CPU_T2: st_d = ctcbi_pkg::CPU_T3;
			ctcbi_pkg::CPU_T3: begin
				rsp_d = BUS.data_bus;
				rv_d = ~wr_q;
				st_d = ctcbi_pkg::CPU_IDLE;
			end
			// [RULE_17] Fetch leads request by two
			ctcbi_pkg::CPU_ACKM: begin
				if (cnt_q == 4'h0) begin
					cnt_d = 4'(ctcbi_pkg::ACK_WAITS) + REQ_EXTRA_WAITS;
					st_d = ctcbi_pkg::CPU_ACKW;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			// [RULE_19] Auto waits plus extra
			ctcbi_pkg::CPU_ACKW: begin
				if (cnt_q == 4'h0) begin
					rsp_d = BUS.data_bus;
					rv_d = 1'b1;
					st_d = ctcbi_pkg::CPU_IDLE;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			st_q <= ctcbi_pkg::CPU_IDLE;
			wr_q <= 1'b0;
			ack_q <= 1'b0;
			ch_q <= 2'h0;
			dat_q <= 8'h00;
			cnt_q <= 4'h0;
			rsp_q <= 8'h00;
			rv_q <= 1'b0;
		end else begin
			st_q <= st_d;
			wr_q <= wr_d;
			ack_q <= ack_d;
			ch_q <= ch_d;
			dat_q <= dat_d;
			cnt_q <= cnt_d;
			rsp_q <= rsp_d;
			rv_q <= rv_d;
		end
	end

	// Write plus acknowledge from the user is an opcode fetch: fetch and read low
	// in T1 and T2, no I/O request, the byte on the bus through T3
	assign fet = wr_q & ack_q;
	assign t1t2 = (st_q == ctcbi_pkg::CPU_T1 || st_q == ctcbi_pkg::CPU_T2);
	assign t2t3 = (st_q == ctcbi_pkg::CPU_T2 || st_q == ctcbi_pkg::CPU_T3);
	// [RULE_02] Request and select from T2
	// [RULE_04] Fetch inactive in register cycles
	assign BUS.io_request_n = ~((t2t3 & ~fet) | (st_q == ctcbi_pkg::CPU_ACKW));
	assign BUS.chip_enable_n = ~(t2t3 & ~fet);
	assign BUS.read_n = ~((t2t3 & ~wr_q & ~ack_q) | (t1t2 & fet));
	assign BUS.opcode_fetch_n = ~(st_q == ctcbi_pkg::CPU_ACKM || st_q == ctcbi_pkg::CPU_ACKW
		|| (t1t2 && fet));
	assign BUS.channel_select_lo = ch_q[0];
	assign BUS.channel_select_hi = ch_q[1];
	assign BUS.cpu_data = dat_q;
	assign BUS.cpu_data_oe = wr_q & (st_q != ctcbi_pkg::CPU_IDLE);
	assign REQ_READY = (st_q == ctcbi_pkg::CPU_IDLE);
	assign RSP_VALID = rv_q;
	assign RSP_DATA = rsp_q;
	assign IRQ_PENDING = ~BUS.interrupt_n;
endmodule : ctcbi_host
`default_nettype wire

// >>> rtl/ctcbi_if.sv
// Interface joining the counter/timer device end and the CPU end.
// Assumes both ends share CLK_SYS; the data bus is resolved here from the enables.
`timescale 1ns/1ps
`default_nettype none
interface ctcbi_if;
	logic chip_enable_n;
	logic io_request_n;
	logic read_n;
	logic opcode_fetch_n;
	logic channel_select_lo;
	logic channel_select_hi;
	logic [7:0] cpu_data;
	logic cpu_data_oe;
	logic [7:0] dev_data;
	logic dev_data_oe;
	logic [7:0] data_bus;
	logic interrupt_n;
	logic chain_enable_in;
	logic chain_enable_out;
	// Bus resolution: device wins whenever it drives, even over the CPU; FF when neither drives
	assign data_bus = dev_data_oe ? dev_data : (cpu_data_oe ? cpu_data : 8'hFF);
	modport device (
		input chip_enable_n, io_request_n, read_n, opcode_fetch_n,
		input channel_select_lo, channel_select_hi, data_bus, chain_enable_in,
		output dev_data, dev_data_oe, interrupt_n, chain_enable_out
	);
	modport host (
		output chip_enable_n, io_request_n, read_n, opcode_fetch_n,
		output channel_select_lo, channel_select_hi, cpu_data, cpu_data_oe,
		input data_bus, interrupt_n
	);
endinterface : ctcbi_if
`default_nettype wire

// >>> rtl/ctcbi_pkg.sv
// Package of constants shared by both ends of the counter/timer CPU link.
// Assumes a single system clock; every timing count here is counted in CLK_SYS cycles.
package ctcbi_pkg;
	localparam int NUM_CH = 4;
	localparam int SEL_W = 2;
	localparam int DATA_W = 8;
	// Control word field positions
	localparam int CW_IS_CTRL = 0;
	localparam int CW_RESET = 1;
	localparam int CW_TC_NEXT = 2;
	localparam int CW_TRIG_EN = 3;
	localparam int CW_EDGE_POS = 4;
	localparam int CW_PRESC256 = 5;
	localparam int CW_COUNTER = 6;
	localparam int CW_INT_EN = 7;
	// Vector field positions
	localparam int VEC_CH_LSB = 1;
	localparam int VEC_HI_LSB = 3;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h02;
	localparam logic [7:0] TC_RST = 8'h00;
	localparam logic [4:0] VEC_HI_RST = 5'h00;
	// Return-from-interrupt opcode bytes
	localparam logic [7:0] RETURN_FROM_INTERRUPT_OPCODE_FIRST = 8'hED;
	localparam logic [7:0] RETURN_FROM_INTERRUPT_OPCODE_SECOND = 8'h4D;
	// Prescaler lengths
	localparam logic [8:0] PRESC_SHORT = 9'h010;
	localparam logic [8:0] PRESC_LONG = 9'h100;
	// Cycles from opcode fetch to I/O request in an acknowledge
	localparam int ACK_M1_LEAD = 2;
	// Automatic wait states in an acknowledge
	localparam int ACK_WAITS = 2;
	// CPU bus cycle phases (host end)
	typedef enum logic [5:0] {
		CPU_IDLE = 6'h01,
		CPU_T1 = 6'h02,
		CPU_T2 = 6'h04,
		CPU_T3 = 6'h08,
		CPU_ACKM = 6'h10,
		CPU_ACKW = 6'h20
	} ctcbi_cpu_st_t;
endpackage : ctcbi_pkg
